// ===== verilog/dac_ctrl_regs.svh
// Register offsets, field positions, reset values and timing constants
`ifndef DAC_CTRL_REGS_SVH
`define DAC_CTRL_REGS_SVH
`define OFS_OPERATION 8'h01
`define OFS_CODE 8'h21
`define OFS_MARGIN_HI 8'h25
`define OFS_MARGIN_LO 8'h26
`define OFS_ALARM_CFG 8'h40
`define OFS_TRIGGER 8'hd3
`define TRIG_RESET 16'h0008
`define CODE_RESET 16'h0000
`define ALARM_RESET 16'h0000
`define TRIG_UNLOCK_MSB 15
`define TRIG_UNLOCK_LSB 12
`define TRIG_CFG_RESET 9
`define TRIG_WAVE_RUN 8
`define TRIG_MARGIN_HI 7
`define TRIG_MARGIN_LO 6
`define TRIG_RECALL 5
`define TRIG_PROGRAM 4
`define UNLOCK_CODE 4'h5
`define SWRST_IDLE 4'h8
`define SWRST_GO 4'ha
`define OP_OFF 8'h00
`define OP_ON 8'h80
`define OP_MARGIN_HI 8'ha4
`define OP_MARGIN_LO 8'h94
`define ALARM_HP_BIT 10
`define ALARM_MP_BIT 9
`define ALARM_LP_BIT 8
`define ALARM_CFG_MASK 16'h073f
`define CLK_HZ 25000000
`define TICK_MS 1
`define CYCLES_PER_MS (`CLK_HZ / 1000 * `TICK_MS)
`define LP_GAP_MS 16000
`endif

// ===== verilog/dac_ctrl_pkg.sv
// Types shared by the converter control block and its alarm timer
package dac_ctrl_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } reg_req_t;
  typedef struct packed {
    logic [9:0] code;
    logic [9:0] margin_hi;
    logic [9:0] margin_lo;
  } storage_image_t;
  typedef struct packed {
    logic hp;
    logic mp;
    logic lp;
    logic [1:0] gap;
    logic [1:0] off;
    logic [1:0] on;
  } alarm_cfg_t;
  typedef enum logic [1:0] {
    TONE_IDLE = 2'b00,
    TONE_ON = 2'b01,
    TONE_OFF = 2'b10,
    TONE_GAP = 2'b11
  } tone_state_t;
endpackage

// ===== verilog/alarm_tone_timer.sv
// Alarm tone burst sequencer driven by the alarm configuration fields
`timescale 1ns/1ns
`include "dac_ctrl_regs.svh"
module alarm_tone_timer #(
  parameter int CYCLES_PER_MS = `CYCLES_PER_MS,
  parameter int PULSES_PER_BURST = 3
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Configuration
  input wire dac_ctrl_pkg::alarm_cfg_t cfg_in,
  // Tone
  output logic tone_out
);
  dac_ctrl_pkg::tone_state_t state_reg;
  logic [15:0] tick_reg;
  logic [13:0] ms_reg;
  logic [3:0] pulse_reg;
  logic [13:0] on_ms, off_ms, gap_ms;
  logic ms_tick;
  logic active;

  assign active = cfg_in.hp | cfg_in.mp | cfg_in.lp;
  assign ms_tick = (tick_reg == 16'(CYCLES_PER_MS - 1));

  // Highest priority wins when several are set
  always_comb begin
    if (cfg_in.hp) begin
      unique case (cfg_in.off)
        2'b00: off_ms = 14'd15; // see RULE14
        2'b01: off_ms = 14'd36;
        2'b10: off_ms = 14'd58;
        2'b11: off_ms = 14'd80;
      endcase
      unique case (cfg_in.on)
        2'b00: on_ms = 14'd80;
        2'b01: on_ms = 14'd103;
        2'b10: on_ms = 14'd126;
        2'b11: on_ms = 14'd150;
      endcase
      unique case (cfg_in.gap)
        2'b00: gap_ms = 14'd2550;
        2'b01: gap_ms = 14'd2960;
        2'b10: gap_ms = 14'd3380;
        2'b11: gap_ms = 14'd3800;
      endcase
    end else begin
      unique case (cfg_in.off)
        2'b00: off_ms = 14'd40; // see RULE12
        2'b01: off_ms = 14'd60;
        2'b10: off_ms = 14'd80;
        2'b11: off_ms = 14'd100;
      endcase
      unique case (cfg_in.on)
        2'b00: on_ms = 14'd130; // see RULE13
        2'b01: on_ms = 14'd153;
        2'b10: on_ms = 14'd176;
        2'b11: on_ms = 14'd200;
      endcase
      if (cfg_in.mp) begin
        unique case (cfg_in.gap)
          2'b00: gap_ms = 14'd2600;
          2'b01: gap_ms = 14'd3060;
          2'b10: gap_ms = 14'd3520;
          2'b11: gap_ms = 14'd4000;
        endcase
      end else begin
        gap_ms = 14'(`LP_GAP_MS); // see RULE11
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in || !active || ms_tick) begin
      tick_reg <= 16'h0000;
    end else begin
      tick_reg <= tick_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in || !active) begin
      state_reg <= dac_ctrl_pkg::TONE_IDLE;
      ms_reg <= 14'h0000;
      pulse_reg <= 4'h0;
    end else if (state_reg == dac_ctrl_pkg::TONE_IDLE) begin
      state_reg <= dac_ctrl_pkg::TONE_ON;
      ms_reg <= 14'h0000;
      pulse_reg <= 4'h0;
    end else if (ms_tick) begin
      ms_reg <= ms_reg + 14'h0001;
      unique case (state_reg)
        dac_ctrl_pkg::TONE_ON: begin
          if (ms_reg + 14'h0001 >= on_ms) begin
            state_reg <= dac_ctrl_pkg::TONE_OFF;
            ms_reg <= 14'h0000;
            pulse_reg <= pulse_reg + 4'h1;
          end
        end
        dac_ctrl_pkg::TONE_OFF: begin
          if (ms_reg + 14'h0001 >= off_ms) begin
            ms_reg <= 14'h0000;
            state_reg <= (pulse_reg >= 4'(PULSES_PER_BURST)) ?
                         dac_ctrl_pkg::TONE_GAP : dac_ctrl_pkg::TONE_ON;
          end
        end
        dac_ctrl_pkg::TONE_GAP: begin
          if (ms_reg + 14'h0001 >= gap_ms) begin
            ms_reg <= 14'h0000;
            pulse_reg <= 4'h0;
            state_reg <= dac_ctrl_pkg::TONE_ON;
          end
        end
        dac_ctrl_pkg::TONE_IDLE: begin
          ms_reg <= 14'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      tone_out <= 1'b0;
    end else begin
      tone_out <= active && (state_reg == dac_ctrl_pkg::TONE_ON);
    end
  end
endmodule

// ===== verilog/dac_trigger_alarm_control.sv
// Trigger, converter code, margin and alarm configuration register logic
`timescale 1ns/1ns
`include "dac_ctrl_regs.svh"
// How it works
// RULE1: Trigger at D3h, resets to 0008h.
// RULE2: Code 0101 in top nibble unlocks device.
// RULE3: Bit 9 restores factory defaults; zero ignored.
// RULE4: Bit 8 runs continuous waveform generation.
// RULE5: Bit 7 ramps to margin high, self-clears.
// RULE6: Bit 6 ramps to margin low, self-clears.
// RULE7: Bit 5 recalls storage, busy, self-clears.
// RULE8: Bit 4 programs storage, busy, self-clears.
// RULE9: Soft reset 1010 recalls, defaults rest.
// RULE10: Trigger bits 11:10 are ignored.
// RULE11: Low priority burst gap always 16 s.
// RULE12: Low priority off time 40-100 ms.
// RULE13: Low priority on time 130-200 ms.
// RULE14: High priority off time 15-80 ms.
// RULE15: Alarm bits 7:6 reserved, read zero.
// RULE16: Code register at 21h, resets 0000h.
// RULE17: Code write updates output at once.
// RULE18: Operation byte: off, on, margin high/low.
// RULE19: Self-clearing bits read zero when done.
module dac_trigger_alarm_control #(
  parameter int CODE_BITS = 10,
  parameter int CYCLES_PER_MS = `CYCLES_PER_MS,
  parameter int PULSES_PER_BURST = 3
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Register access from the serial interface
  input wire dac_ctrl_pkg::reg_req_t req_in,
  output logic [15:0] rdata_out,
  output logic rvalid_out,
  // Nonvolatile storage handshake
  output logic storage_recall_req_out,
  output logic storage_write_req_out,
  output dac_ctrl_pkg::storage_image_t storage_wdata_out,
  input wire dac_ctrl_pkg::storage_image_t storage_rdata_in,
  input wire logic storage_done_in,
  output logic storage_busy_flag_out,
  // Converter and device control
  output logic [9:0] active_code_out,
  output logic output_on_out,
  output logic waveform_run_out,
  output logic unlock_out,
  output logic tone_out
);
  localparam logic [9:0] CODE_MASK = 10'(10'h3ff << (10 - CODE_BITS));

  logic [9:0] code_reg;
  logic [9:0] margin_hi_reg;
  logic [9:0] margin_lo_reg;
  logic [9:0] active_reg;
  logic [7:0] op_reg;
  logic [15:0] alarm_reg;
  logic margin_hi_reg_bit;
  logic margin_lo_reg_bit;
  logic recall_reg;
  logic program_reg;
  logic wave_reg;
  logic unlock_reg;
  logic out_on_reg;
  logic wr_trig;
  logic wr_code;
  logic wr_op;
  logic cfg_reset;
  logic soft_reset;
  logic busy;
  logic recall_done;
  logic [9:0] wr_field;
  logic [9:0] margin_target;
  logic margin_active;
  dac_ctrl_pkg::alarm_cfg_t alarm_cfg;

  assign wr_trig = req_in.wr && (req_in.addr == `OFS_TRIGGER); // see RULE1
  assign wr_code = req_in.wr && (req_in.addr == `OFS_CODE); // see RULE16
  assign wr_op = req_in.wr && (req_in.addr == `OFS_OPERATION);
  assign wr_field = req_in.wdata[11:2] & CODE_MASK; // see RULE17
  // Only a one starts the reset; a zero in bit 9 does nothing
  assign cfg_reset = wr_trig && req_in.wdata[`TRIG_CFG_RESET]; // see RULE3
  assign soft_reset = wr_trig && (req_in.wdata[3:0] == `SWRST_GO); // see RULE9
  assign busy = recall_reg | program_reg;
  assign recall_done = recall_reg && storage_done_in;
  assign margin_active = margin_hi_reg_bit | margin_lo_reg_bit;
  assign margin_target = margin_hi_reg_bit ? margin_hi_reg : margin_lo_reg;

  // Unlock, waveform run and output on/off
  always_ff @(posedge clk_in) begin
    if (srst_in || cfg_reset || soft_reset) begin
      unlock_reg <= 1'b0;
      wave_reg <= 1'b0;
    end else if (wr_trig) begin
      // Bits 11:10 are never decoded
      if (req_in.wdata[`TRIG_UNLOCK_MSB:`TRIG_UNLOCK_LSB] == `UNLOCK_CODE) begin
        unlock_reg <= 1'b1; // see RULE2
      end
      wave_reg <= req_in.wdata[`TRIG_WAVE_RUN]; // see RULE4 RULE10
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in || cfg_reset || soft_reset) begin
      op_reg <= 8'h00;
      out_on_reg <= 1'b0;
    end else if (wr_op) begin
      op_reg <= req_in.wdata[15:8];
      if (req_in.wdata[15:8] == `OP_OFF) begin
        out_on_reg <= 1'b0; // see RULE18
      end else if (req_in.wdata[15:8] == `OP_ON) begin
        out_on_reg <= 1'b1; // see RULE18
      end
    end
  end

  // Margin commands; a new request wins over completion in the same cycle
  always_ff @(posedge clk_in) begin
    if (srst_in || cfg_reset || soft_reset) begin
      margin_hi_reg_bit <= 1'b0;
      margin_lo_reg_bit <= 1'b0;
    end else if (wr_trig && req_in.wdata[`TRIG_MARGIN_HI]) begin
      margin_hi_reg_bit <= 1'b1; // see RULE5
      margin_lo_reg_bit <= 1'b0;
    end else if (wr_trig && req_in.wdata[`TRIG_MARGIN_LO]) begin
      margin_hi_reg_bit <= 1'b0;
      margin_lo_reg_bit <= 1'b1; // see RULE6
    end else if (wr_op && req_in.wdata[15:8] == `OP_MARGIN_HI) begin
      margin_hi_reg_bit <= 1'b1; // see RULE18
      margin_lo_reg_bit <= 1'b0;
    end else if (wr_op && req_in.wdata[15:8] == `OP_MARGIN_LO) begin
      margin_hi_reg_bit <= 1'b0;
      margin_lo_reg_bit <= 1'b1; // see RULE18
    end else if (margin_active && active_reg == margin_target) begin
      margin_hi_reg_bit <= 1'b0; // see RULE5 RULE6 RULE19
      margin_lo_reg_bit <= 1'b0;
    end
  end

  // Storage recall and program; triggers while busy are dropped
  always_ff @(posedge clk_in) begin
    if (srst_in || cfg_reset) begin
      recall_reg <= 1'b0;
      program_reg <= 1'b0;
    end else if (busy) begin
      if (storage_done_in) begin
        recall_reg <= 1'b0; // see RULE7 RULE19
        program_reg <= 1'b0; // see RULE8 RULE19
      end
    end else if (soft_reset) begin
      recall_reg <= 1'b1; // see RULE9
    end else if (wr_trig && req_in.wdata[`TRIG_RECALL]) begin
      recall_reg <= 1'b1; // see RULE7
    end else if (wr_trig && req_in.wdata[`TRIG_PROGRAM]) begin
      program_reg <= 1'b1; // see RULE8
    end
  end

  // Code registers: defaults on configuration reset, image on recall
  always_ff @(posedge clk_in) begin
    if (srst_in || cfg_reset) begin
      code_reg <= 10'(`CODE_RESET >> 2);
      margin_hi_reg <= 10'h000;
      margin_lo_reg <= 10'h000;
    end else if (recall_done) begin
      code_reg <= storage_rdata_in.code & CODE_MASK; // see RULE7 RULE9
      margin_hi_reg <= storage_rdata_in.margin_hi & CODE_MASK;
      margin_lo_reg <= storage_rdata_in.margin_lo & CODE_MASK;
    end else if (req_in.wr) begin
      if (wr_code) begin
        code_reg <= wr_field;
      end
      if (req_in.addr == `OFS_MARGIN_HI) begin
        margin_hi_reg <= wr_field;
      end
      if (req_in.addr == `OFS_MARGIN_LO) begin
        margin_lo_reg <= wr_field;
      end
    end
  end

  // Active output code: direct write beats recall beats margin ramp
  always_ff @(posedge clk_in) begin
    if (srst_in || cfg_reset) begin
      active_reg <= 10'h000;
    end else if (wr_code) begin
      active_reg <= wr_field; // see RULE17
    end else if (recall_done) begin
      active_reg <= storage_rdata_in.code & CODE_MASK;
    end else if (margin_active && active_reg < margin_target) begin
      active_reg <= active_reg + 10'h001; // see RULE5 RULE6
    end else if (margin_active && active_reg > margin_target) begin
      active_reg <= active_reg - 10'h001;
    end
  end

  // Alarm configuration; reserved bits 7:6 are masked off
  always_ff @(posedge clk_in) begin
    if (srst_in || cfg_reset || soft_reset) begin
      alarm_reg <= `ALARM_RESET;
    end else if (req_in.wr && req_in.addr == `OFS_ALARM_CFG) begin
      alarm_reg <= req_in.wdata & `ALARM_CFG_MASK; // see RULE15
    end
  end

  assign alarm_cfg.hp = alarm_reg[`ALARM_HP_BIT];
  assign alarm_cfg.mp = alarm_reg[`ALARM_MP_BIT];
  assign alarm_cfg.lp = alarm_reg[`ALARM_LP_BIT];
  assign alarm_cfg.gap = alarm_reg[5:4];
  assign alarm_cfg.off = alarm_reg[3:2];
  assign alarm_cfg.on = alarm_reg[1:0];

  alarm_tone_timer #(
    .CYCLES_PER_MS(CYCLES_PER_MS),
    .PULSES_PER_BURST(PULSES_PER_BURST)
  ) u_tone (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .cfg_in(alarm_cfg),
    .tone_out(tone_out)
  );

  // Read path: trigger shows live command state, soft reset field idles
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rdata_out <= 16'h0000;
      rvalid_out <= 1'b0;
    end else begin
      rvalid_out <= req_in.rd;
      if (req_in.rd) begin
        unique case (req_in.addr)
          `OFS_TRIGGER: rdata_out <= {8'h00, margin_hi_reg_bit, margin_lo_reg_bit,
                                      recall_reg, program_reg, `SWRST_IDLE}; // see RULE1 RULE19
          `OFS_OPERATION: rdata_out <= {op_reg, 8'h00};
          default: rdata_out <= 16'h0000;
        endcase
      end
    end
  end

  assign storage_recall_req_out = recall_reg;
  assign storage_write_req_out = program_reg;
  assign storage_busy_flag_out = busy; // see RULE7 RULE8
  assign storage_wdata_out.code = code_reg;
  assign storage_wdata_out.margin_hi = margin_hi_reg;
  assign storage_wdata_out.margin_lo = margin_lo_reg;
  assign active_code_out = active_reg;
  assign output_on_out = out_on_reg;
  assign waveform_run_out = wave_reg;
  assign unlock_out = unlock_reg;
endmodule

// ===== verif/dac_ctrl_props.sv
// Port-level assertions for the trigger and converter control block
`timescale 1ns/1ns
module dac_ctrl_props (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Watched ports
  input wire dac_ctrl_pkg::reg_req_t req_in,
  input wire logic rvalid_out,
  input wire logic storage_recall_req_out,
  input wire logic storage_write_req_out,
  input wire logic storage_done_in,
  input wire logic storage_busy_flag_out,
  input wire logic [9:0] active_code_out,
  input wire logic output_on_out,
  input wire logic waveform_run_out,
  input wire logic unlock_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  logic trig_wr;
  logic trig_any;
  // Resets in the same write override the plain field effects
  assign trig_any = req_in.wr && req_in.addr == 8'hd3;
  assign trig_wr = trig_any && !req_in.wdata[9] && req_in.wdata[3:0] != 4'ha;
  read_answer_a: assert property (rvalid_out == $past(req_in.rd))
    else $error("read answer not one cycle after request");
  busy_level_a: assert property (storage_busy_flag_out ==
    (storage_recall_req_out || storage_write_req_out)) else $error("busy flag mismatch");
  code_update_a: assert property (req_in.wr && req_in.addr == 8'h21 |=>
    active_code_out == $past(req_in.wdata[11:2])) else $error("code not applied");
  wave_bit_a: assert property (trig_wr |=> waveform_run_out == $past(req_in.wdata[8]))
    else $error("waveform run bit mismatch");
  unlock_set_a: assert property (trig_wr && req_in.wdata[15:12] == 4'h5 |=> unlock_out)
    else $error("unlock not set");
  recall_go_a: assert property (trig_wr && req_in.wdata[5] && !storage_busy_flag_out
    |=> storage_recall_req_out && storage_busy_flag_out) else $error("recall not started");
  prog_go_a: assert property (trig_wr && req_in.wdata[4] && !req_in.wdata[5]
    && !storage_busy_flag_out |=> storage_write_req_out) else $error("program not started");
  swrst_go_a: assert property (trig_any && !req_in.wdata[9] && req_in.wdata[3:0] == 4'ha
    && !storage_busy_flag_out |=> storage_recall_req_out) else $error("soft reset no recall");
  done_end_a: assert property (storage_busy_flag_out && storage_done_in |=>
    !storage_busy_flag_out) else $error("busy outlived done");
  op_on_a: assert property (req_in.wr && req_in.addr == 8'h01 && req_in.wdata[15:8] == 8'h80
    |=> output_on_out) else $error("output not on");
  op_off_a: assert property (req_in.wr && req_in.addr == 8'h01 && req_in.wdata[15:8] == 8'h00
    |=> !output_on_out) else $error("output not off");
  cfg_reset_a: assert property (trig_any && req_in.wdata[9] |=>
    active_code_out == 10'h000 && !unlock_out) else $error("config reset incomplete");
endmodule
bind dac_trigger_alarm_control dac_ctrl_props u_props (.clk_in(clk_in), .srst_in(srst_in),
  .req_in(req_in), .rvalid_out(rvalid_out), .storage_recall_req_out(storage_recall_req_out),
  .storage_write_req_out(storage_write_req_out), .storage_done_in(storage_done_in),
  .storage_busy_flag_out(storage_busy_flag_out), .active_code_out(active_code_out),
  .output_on_out(output_on_out), .waveform_run_out(waveform_run_out), .unlock_out(unlock_out));

// ===== verif/storage_model.sv
// Behavioural nonvolatile storage answering recall and program requests
`timescale 1ns/1ns
module storage_model #(
  parameter int LATENCY = 8
) (
  input wire logic clk_in,
  input wire logic recall_req_in,
  input wire logic write_req_in,
  input wire dac_ctrl_pkg::storage_image_t wdata_in,
  output dac_ctrl_pkg::storage_image_t rdata_out,
  output logic done_out
);
  int count = 0;
  initial rdata_out = '{code: 10'h155, margin_hi: 10'h2aa, margin_lo: 10'h0f0};
  initial done_out = 1'b0;
  // Guard on done: the request is still high at the edge after the pulse
  always @(posedge clk_in) begin
    done_out <= 1'b0;
    if ((recall_req_in || write_req_in) && !done_out) begin
      count <= count + 1;
      if (count == LATENCY) begin
        done_out <= 1'b1;
        count <= 0;
        if (write_req_in) begin
          rdata_out <= wdata_in;
        end
      end
    end
  end
endmodule

// ===== verif/testbench.sv
// Self-checking bench for the trigger, code and alarm control block
`timescale 1ns/1ns
module testbench;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  dac_ctrl_pkg::reg_req_t req_in = '0;
  dac_ctrl_pkg::storage_image_t wimage, rimage;
  logic [15:0] rdata_out;
  logic [9:0] active_code_out;
  logic rvalid_out, recall_req, write_req, done, busy, output_on_out, run, unlock, tone;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;
  int lp_on[4] = '{130, 153, 176, 200};
  int lp_off[4] = '{40, 60, 80, 100};
  int hp_on[4] = '{80, 103, 126, 150};
  int hp_off[4] = '{15, 36, 58, 80};
  always #20 clk_in = ~clk_in;
  dac_trigger_alarm_control #(.CYCLES_PER_MS(10)) u_dac_trigger_alarm_control (
    .clk_in(clk_in), .srst_in(srst_in), .req_in(req_in), .rdata_out(rdata_out),
    .rvalid_out(rvalid_out), .storage_recall_req_out(recall_req),
    .storage_write_req_out(write_req), .storage_wdata_out(wimage),
    .storage_rdata_in(rimage), .storage_done_in(done), .storage_busy_flag_out(busy),
    .active_code_out(active_code_out), .output_on_out(output_on_out),
    .waveform_run_out(run), .unlock_out(unlock), .tone_out(tone));
  storage_model #(.LATENCY(8)) u_storage_model (.clk_in(clk_in), .recall_req_in(recall_req),
    .write_req_in(write_req), .wdata_in(wimage), .rdata_out(rimage), .done_out(done));
  task automatic wrap_up();
    if (fails == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Timer phase edges may land up to two cycles either way
  task automatic check_near(input int got, input int exp);
    checks_done++;
    if (got < exp - 2 || got > exp + 2) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_in);
    req_in <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk_in);
    req_in.wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(negedge clk_in);
    req_in <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(negedge clk_in);
    req_in.rd <= 1'b0;
    check({15'h0000, rvalid_out}, 16'h0001);
    check(rdata_out, exp);
  endtask
  task automatic wait_code(input logic [9:0] tgt);
    for (int i = 0; i < 1200 && active_code_out !== tgt; i++) @(negedge clk_in);
    check({6'h00, active_code_out}, {6'h00, tgt});
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 100 && busy !== 1'b0; i++) @(negedge clk_in);
    check({15'h0000, busy}, 16'h0000);
  endtask
  task automatic t_regs();
    rd_chk(8'hd3, 16'h0008);
    rd_chk(8'h7e, 16'h0000);
    check({6'h00, active_code_out}, 16'h0000);
    wr(8'h21, 16'h0ffc);
    check({6'h00, active_code_out}, 16'h03ff);
    wr(8'hd3, 16'h5c08);
    check({unlock, run}, 16'h0002);
    rd_chk(8'hd3, 16'h0008);
    wr(8'hd3, 16'h0108);
    check({15'h0000, run}, 16'h0001);
    wr(8'hd3, 16'h0008);
    check({15'h0000, run}, 16'h0000);
  endtask
  task automatic t_margin();
    wr(8'h25, 16'h0fc0);
    wr(8'h26, 16'h0040);
    wr(8'hd3, 16'h0088);
    rd_chk(8'hd3, 16'h0088);
    wait_code(10'h3f0);
    rd_chk(8'hd3, 16'h0008);
    wr(8'hd3, 16'h0048);
    wait_code(10'h010);
    rd_chk(8'hd3, 16'h0008);
    wr(8'h01, 16'h8000);
    check({15'h0000, output_on_out}, 16'h0001);
    rd_chk(8'h01, 16'h8000);
    wr(8'h01, 16'h0000);
    check({15'h0000, output_on_out}, 16'h0000);
    wr(8'h01, 16'ha400);
    wait_code(10'h3f0);
    wr(8'h01, 16'h9400);
    wait_code(10'h010);
  endtask
  task automatic t_storage();
    wr(8'h21, 16'h0ffc);
    wr(8'hd3, 16'h0018);
    check({15'h0000, write_req}, 16'h0001);
    wr(8'hd3, 16'h0028);
    wait_idle();
    check({recall_req, 5'h00, rimage.code}, 16'h03ff);
    wr(8'h21, 16'h0040);
    wr(8'hd3, 16'h0028);
    check({15'h0000, busy}, 16'h0001);
    wait_idle();
    check({6'h00, active_code_out}, 16'h03ff);
    rd_chk(8'hd3, 16'h0008);
    wr(8'hd3, 16'h5008);
    wr(8'h21, 16'h0000);
    wr(8'hd3, 16'h000a);
    wait_idle();
    check({unlock, 5'h00, active_code_out}, 16'h03ff);
    wr(8'hd3, 16'h5008);
    wr(8'hd3, 16'h0208);
    check({busy, unlock, 4'h0, active_code_out}, 16'h0000);
  endtask
  task automatic t_tone(input logic [15:0] cfg, input int on_ms, input int off_ms);
    int n_on = 0;
    int n_off = 0;
    wr(8'h40, cfg);
    for (int i = 0; i < 3000 && tone !== 1'b1; i++) @(negedge clk_in);
    while (tone === 1'b1 && n_on < 3000) begin
      @(negedge clk_in);
      n_on++;
    end
    while (tone === 1'b0 && n_off < 3000) begin
      @(negedge clk_in);
      n_off++;
    end
    check_near(n_on, on_ms * 10);
    check_near(n_off, off_ms * 10);
    wr(8'h40, 16'h0000);
    repeat (4) @(negedge clk_in);
  endtask
  initial begin
    repeat (6) @(negedge clk_in);
    srst_in <= 1'b0;
    t_regs();
    t_margin();
    t_storage();
    for (int i = 0; i < 4; i++) begin
      // Low priority runs set reserved and gap bits too: neither may change on or off time
      t_tone(16'(16'h01c0 | (i << 4) | (i << 2) | i), lp_on[i], lp_off[i]);
      t_tone(16'(16'h0400 | (i << 2) | i), hp_on[i], hp_off[i]);
    end
    wrap_up();
  end
endmodule
